/* File: local_interrupt_unit.sv */
// Local interrupt unit: registers, start-up message sender, local pin and error delivery.
//
// Contract
// - Unit enable is bit 8 of spurious vector control, zero at reset, gates message sending and all interrupt delivery.
// - Identifier sits in bits 24 to 27; boot processor identifier resets to zero.
// - Identifier lsb is bit 24, so toggling it names the neighbour processor.
// - Start-up message carries 8-bit vector; start address is vector shifted left twelve.
// - Low command mode 110 selects start-up; vector is low byte, fields under mask.
// - High command word written first; writing low command word sends the message.
// - Error entry low byte is vector raised on local errors like failed delivery.
// - Error interrupts are delivered only while the unit enable bit is set.
// - Pin entry bits 8 to 10: 111b external-controller mode, 100b non-maskable.
// - Entry bit 16 masks: zero passes the interrupt, one blocks it.
// - Pin entry bit 15 selects trigger; zero means edge-triggered.
// - Pin entry bit 13 selects polarity; zero means active high.
// - External-controller mode forwards pin 0 events to the maskable interrupt input.
// - Non-maskable mode delivers pin 1 events as non-maskable interrupts.
module local_interrupt_unit #(
   parameter logic [local_interrupt_unit_pkg::ID_W-1:0] LOCAL_ID =
      local_interrupt_unit_pkg::RST_LOCAL_ID,
   parameter int ACK_WAIT = local_interrupt_unit_pkg::ACK_WAIT_CYCLES
) (
   // Clock and reset
   input  wire logic                                       i_ref_clk,
   input  wire logic                                       i_nrst,
   // Register access from the host core
   input  wire local_interrupt_unit_pkg::reg_req_t         i_req,
   output logic [31:0]                                     o_rdata,
   output logic                                            o_rd_valid,
   // Local interrupt pins
   input  wire logic                                       i_local_pin0,
   input  wire logic                                       i_local_pin1,
   // Message link to the peer unit
   output local_interrupt_unit_pkg::inter_processor_message_t o_msg,
   input  wire logic                                       i_msg_ack,
   input  wire logic                                       i_msg_reject,
   // Interrupts to the core
   output logic                                            o_maskable_int,
   output logic                                            o_nmi,
   output logic                                            o_err_irq,
   output logic [local_interrupt_unit_pkg::VEC_W-1:0]      o_err_vector,
   output logic                                            o_unit_enabled
);

   localparam logic [local_interrupt_unit_pkg::ACK_CNT_W-1:0] ACK_LAST =
      local_interrupt_unit_pkg::ACK_CNT_W'(ACK_WAIT - 1);

   typedef struct packed {
      logic [local_interrupt_unit_pkg::ID_W-1:0]       local_id;
      logic [31:0]                                     spurious_ctl;
      logic [31:0]                                     cmd_low;
      logic [31:0]                                     cmd_high;
      logic [31:0]                                     pin0_entry;
      logic [31:0]                                     pin1_entry;
      logic [31:0]                                     err_entry;
      local_interrupt_unit_pkg::send_state_t           send_state;
      logic [local_interrupt_unit_pkg::ACK_CNT_W-1:0]  ack_cnt;
      logic [31:0]                                     rdata;
      logic                                            rd_valid;
      local_interrupt_unit_pkg::inter_processor_message_t msg;
      logic                                            maskable_int;
      logic                                            nmi;
      logic                                            err_irq;
      logic [local_interrupt_unit_pkg::VEC_W-1:0]      err_vector;
   } unit_state_t;

   unit_state_t state_r;
   unit_state_t state_nxt;
   logic        pin0_event;
   logic        pin1_event;

   // ==========================================================================
   // Field helpers
   // ==========================================================================
   function automatic logic [local_interrupt_unit_pkg::MODE_W-1:0] entry_mode(
      input logic [31:0] entry);
      entry_mode = entry[local_interrupt_unit_pkg::MODE_LSB +:
                         local_interrupt_unit_pkg::MODE_W];
   endfunction

   function automatic logic entry_open(input logic [31:0] entry);
      entry_open = ~entry[local_interrupt_unit_pkg::MASK_BIT];
   endfunction

   function automatic logic [local_interrupt_unit_pkg::VEC_W-1:0] entry_vector(
      input logic [31:0] entry);
      entry_vector = entry[local_interrupt_unit_pkg::VEC_LSB +:
                           local_interrupt_unit_pkg::VEC_W];
   endfunction

   // One pin may feed either core input, depending on its programmed mode.
   function automatic logic pin_delivers(
      input logic                                       evt,
      input logic [31:0]                                entry,
      input logic [local_interrupt_unit_pkg::MODE_W-1:0] mode);
      pin_delivers = evt & entry_open(entry) & (entry_mode(entry) == mode);
   endfunction

   // ==========================================================================
   // Pin qualifiers
   // ==========================================================================
   local_pin_event_detect u_pin0 (
      .i_ref_clk    (i_ref_clk),
      .i_nrst       (i_nrst),
      .i_pin        (i_local_pin0),
      .i_active_low (state_r.pin0_entry[local_interrupt_unit_pkg::POLARITY_BIT]),
      .i_level_mode (state_r.pin0_entry[local_interrupt_unit_pkg::TRIGGER_BIT]),
      .o_event      (pin0_event)
   );

   local_pin_event_detect u_pin1 (
      .i_ref_clk    (i_ref_clk),
      .i_nrst       (i_nrst),
      .i_pin        (i_local_pin1),
      .i_active_low (state_r.pin1_entry[local_interrupt_unit_pkg::POLARITY_BIT]),
      .i_level_mode (state_r.pin1_entry[local_interrupt_unit_pkg::TRIGGER_BIT]),
      .o_event      (pin1_event)
   );

   // ==========================================================================
   // Next state
   // ==========================================================================
   logic enabled;
   logic send_req;
   logic send_fail;
   logic pending;

   always_comb begin
      state_nxt = state_r;
      enabled   = state_r.spurious_ctl[local_interrupt_unit_pkg::UNIT_ENABLE_BIT];
      pending   = (state_r.send_state == local_interrupt_unit_pkg::SEND_WAIT);
      send_req  = 1'b0;
      send_fail = 1'b0;

      state_nxt.rd_valid  = 1'b0;
      state_nxt.msg.valid = 1'b0;
      state_nxt.err_irq   = 1'b0;

      // Register writes other than the identifier store the whole word, so untouched bits
      // survive a read-modify-write by software.
      if (i_req.wr) begin
         case (i_req.addr)
            local_interrupt_unit_pkg::ADDR_LOCAL_UNIT_IDENTIFIER: begin
               state_nxt.local_id = i_req.wdata[local_interrupt_unit_pkg::ID_LSB +:
                                                local_interrupt_unit_pkg::ID_W];
            end
            local_interrupt_unit_pkg::ADDR_SPURIOUS_VECTOR_CONTROL: begin
               state_nxt.spurious_ctl = i_req.wdata;
            end
            local_interrupt_unit_pkg::ADDR_INTERRUPT_COMMAND_LOW: begin
               state_nxt.cmd_low = i_req.wdata;
               send_req          = 1'b1;
            end
            local_interrupt_unit_pkg::ADDR_INTERRUPT_COMMAND_HIGH: begin
               state_nxt.cmd_high = i_req.wdata;
            end
            local_interrupt_unit_pkg::ADDR_LOCAL_PIN0_VECTOR_ENTRY: begin
               state_nxt.pin0_entry = i_req.wdata;
            end
            local_interrupt_unit_pkg::ADDR_LOCAL_PIN1_VECTOR_ENTRY: begin
               state_nxt.pin1_entry = i_req.wdata;
            end
            local_interrupt_unit_pkg::ADDR_ERROR_VECTOR_ENTRY: begin
               state_nxt.err_entry = i_req.wdata;
            end
            default: begin
               state_nxt.rd_valid = 1'b0;
            end
         endcase
      end

      // Reads are answered one cycle later; the pending flag is live state.
      if (i_req.rd) begin
         state_nxt.rd_valid = 1'b1;
         case (i_req.addr)
            local_interrupt_unit_pkg::ADDR_LOCAL_UNIT_IDENTIFIER: begin
               state_nxt.rdata = '0;
               state_nxt.rdata[local_interrupt_unit_pkg::ID_LSB +:
                               local_interrupt_unit_pkg::ID_W] = state_r.local_id;
            end
            local_interrupt_unit_pkg::ADDR_SPURIOUS_VECTOR_CONTROL: begin
               state_nxt.rdata = state_r.spurious_ctl;
            end
            local_interrupt_unit_pkg::ADDR_INTERRUPT_COMMAND_LOW: begin
               state_nxt.rdata = state_r.cmd_low;
               state_nxt.rdata[local_interrupt_unit_pkg::PENDING_BIT] = pending;
            end
            local_interrupt_unit_pkg::ADDR_INTERRUPT_COMMAND_HIGH: begin
               state_nxt.rdata = state_r.cmd_high;
            end
            local_interrupt_unit_pkg::ADDR_LOCAL_PIN0_VECTOR_ENTRY: begin
               state_nxt.rdata = state_r.pin0_entry;
            end
            local_interrupt_unit_pkg::ADDR_LOCAL_PIN1_VECTOR_ENTRY: begin
               state_nxt.rdata = state_r.pin1_entry;
            end
            local_interrupt_unit_pkg::ADDR_ERROR_VECTOR_ENTRY: begin
               state_nxt.rdata = state_r.err_entry;
            end
            default: begin
               state_nxt.rdata = local_interrupt_unit_pkg::UNMAPPED_READ;
            end
         endcase
      end

      // ========================================================================
      // Message sender
      // ========================================================================
      case (state_r.send_state)
         local_interrupt_unit_pkg::SEND_IDLE: begin
            // A command write while disabled is stored but sends nothing.
            if (send_req && enabled) begin
               state_nxt.msg.valid  = 1'b1;
               state_nxt.msg.dest   = state_r.cmd_high[local_interrupt_unit_pkg::ID_LSB +:
                                                       local_interrupt_unit_pkg::ID_W];
               state_nxt.msg.mode   = entry_mode(i_req.wdata);
               state_nxt.msg.vector = entry_vector(i_req.wdata);
               state_nxt.msg.start_addr = local_interrupt_unit_pkg::START_ADDR_W'(
                  {entry_vector(i_req.wdata),
                   {local_interrupt_unit_pkg::PAGE_SHIFT{1'b0}}});
               state_nxt.ack_cnt    = '0;
               state_nxt.send_state = local_interrupt_unit_pkg::SEND_WAIT;
            end
         end
         local_interrupt_unit_pkg::SEND_WAIT: begin
            // A second command write during a pending send is not launched.
            if (i_msg_ack) begin
               state_nxt.send_state = local_interrupt_unit_pkg::SEND_IDLE;
            end else if (i_msg_reject || state_r.ack_cnt == ACK_LAST) begin
               state_nxt.send_state = local_interrupt_unit_pkg::SEND_FAIL;
            end else begin
               state_nxt.ack_cnt = state_r.ack_cnt +
                                   local_interrupt_unit_pkg::ACK_CNT_W'(1);
            end
         end
         local_interrupt_unit_pkg::SEND_FAIL: begin
            send_fail            = 1'b1;
            state_nxt.send_state = local_interrupt_unit_pkg::SEND_IDLE;
         end
         default: begin
            state_nxt.send_state = local_interrupt_unit_pkg::SEND_IDLE;
         end
      endcase

      // ========================================================================
      // Interrupt delivery to the core
      // ========================================================================
      state_nxt.maskable_int = enabled &
         (pin_delivers(pin0_event, state_r.pin0_entry,
                       local_interrupt_unit_pkg::MODE_EXT_CTRL) |
          pin_delivers(pin1_event, state_r.pin1_entry,
                       local_interrupt_unit_pkg::MODE_EXT_CTRL));
      state_nxt.nmi = enabled &
         (pin_delivers(pin1_event, state_r.pin1_entry,
                       local_interrupt_unit_pkg::MODE_NMI) |
          pin_delivers(pin0_event, state_r.pin0_entry,
                       local_interrupt_unit_pkg::MODE_NMI));

      if (send_fail && enabled && entry_open(state_r.err_entry)) begin
         state_nxt.err_irq    = 1'b1;
         state_nxt.err_vector = entry_vector(state_r.err_entry);
      end

      // Disabling the unit abandons a pending send without raising an error.
      if (!enabled) begin
         state_nxt.send_state = local_interrupt_unit_pkg::SEND_IDLE;
      end
   end

   // ==========================================================================
   // State register
   // ==========================================================================
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r.local_id     <= LOCAL_ID;
         state_r.spurious_ctl <= local_interrupt_unit_pkg::RST_SPURIOUS_VECTOR_CONTROL;
         state_r.cmd_low      <= local_interrupt_unit_pkg::RST_COMMAND;
         state_r.cmd_high     <= local_interrupt_unit_pkg::RST_COMMAND;
         state_r.pin0_entry   <= local_interrupt_unit_pkg::RST_VECTOR_ENTRY;
         state_r.pin1_entry   <= local_interrupt_unit_pkg::RST_VECTOR_ENTRY;
         state_r.err_entry    <= local_interrupt_unit_pkg::RST_VECTOR_ENTRY;
         state_r.send_state   <= local_interrupt_unit_pkg::SEND_IDLE;
         state_r.ack_cnt      <= '0;
         state_r.rdata        <= '0;
         state_r.rd_valid     <= 1'b0;
         state_r.msg          <= '0;
         state_r.maskable_int <= 1'b0;
         state_r.nmi          <= 1'b0;
         state_r.err_irq      <= 1'b0;
         state_r.err_vector   <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   assign o_rdata        = state_r.rdata;
   assign o_rd_valid     = state_r.rd_valid;
   assign o_msg          = state_r.msg;
   assign o_maskable_int = state_r.maskable_int;
   assign o_nmi          = state_r.nmi;
   assign o_err_irq      = state_r.err_irq;
   assign o_err_vector   = state_r.err_vector;
   assign o_unit_enabled =
      state_r.spurious_ctl[local_interrupt_unit_pkg::UNIT_ENABLE_BIT];

endmodule // local_interrupt_unit

/* File: local_interrupt_unit_chk.sv */
// Checker with concurrent assertions on the ports of the local interrupt unit.
module local_interrupt_unit_chk #(parameter int ACK_WAIT = 8) (
   // Clock, reset and register requests
   input wire logic                                               i_ref_clk,
   input wire logic                                               i_nrst,
   input wire local_interrupt_unit_pkg::reg_req_t                 i_req,
   // Message link and core side
   input wire local_interrupt_unit_pkg::inter_processor_message_t o_msg,
   input wire logic                                               i_msg_ack,
   input wire logic                                               i_msg_reject,
   input wire logic                                               o_err_irq,
   input wire logic                                               o_unit_enabled
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       wr_hi, wr_lo, wr_sv;
   logic [3:0] hi_r;
   int         cnt_r;
   assign wr_hi = i_req.wr && i_req.addr == local_interrupt_unit_pkg::ADDR_INTERRUPT_COMMAND_HIGH;
   assign wr_lo = i_req.wr && i_req.addr == local_interrupt_unit_pkg::ADDR_INTERRUPT_COMMAND_LOW;
   assign wr_sv = i_req.wr && i_req.addr == local_interrupt_unit_pkg::ADDR_SPURIOUS_VECTOR_CONTROL;
   // Counts unanswered wait cycles; any answer clears it.
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         hi_r  <= 4'h0;
         cnt_r <= 0;
      end else begin
         if (wr_hi) hi_r <= i_req.wdata[27:24];
         if (o_msg.valid) cnt_r <= 1;
         else if (cnt_r != 0 && cnt_r < ACK_WAIT && !i_msg_ack && !i_msg_reject)
            cnt_r <= cnt_r + 1;
         else cnt_r <= 0;
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_sent;
      o_msg.valid;
   endsequence
   sequence s_refused;
      $rose(i_msg_reject);
   endsequence
   a_enable_bit: assert property (wr_sv |=> o_unit_enabled == $past(i_req.wdata[8]))
      else $error("enable bit wrong");
   a_send_enabled: assert property (s_sent |-> $past(o_unit_enabled))
      else $error("sent while disabled");
   a_send_on_low: assert property (s_sent |-> $past(wr_lo))
      else $error("sent without low write");
   a_send_fields: assert property (s_sent |-> o_msg.dest == hi_r
      && o_msg.mode == $past(i_req.wdata[10:8]) && o_msg.vector == $past(i_req.wdata[7:0]))
      else $error("message fields wrong");
   a_page_start: assert property (s_sent |-> o_msg.start_addr == {o_msg.vector, 12'h000})
      else $error("start address wrong");
   a_err_enabled: assert property (o_err_irq |-> $past(o_unit_enabled))
      else $error("error while disabled");
   a_reject_err: assert property (s_refused |-> ##2 o_err_irq)
      else $error("reject gave no error");
   a_timeout_err: assert property (cnt_r == ACK_WAIT |-> ##[0:5] o_err_irq)
      else $error("timeout gave no error");
endmodule // local_interrupt_unit_chk

bind local_interrupt_unit local_interrupt_unit_chk #(.ACK_WAIT(ACK_WAIT)) u_chk (
   .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_req(i_req), .o_msg(o_msg),
   .i_msg_ack(i_msg_ack), .i_msg_reject(i_msg_reject), .o_err_irq(o_err_irq),
   .o_unit_enabled(o_unit_enabled));

/* File: local_interrupt_unit_pkg.sv */
// Package with register map, field layout, reset values and carrier types of the interrupt unit.
package local_interrupt_unit_pkg;

   // ==========================================================================
   // Register byte addresses
   // ==========================================================================
   localparam logic [31:0] ADDR_LOCAL_UNIT_IDENTIFIER   = 32'hFEE0_0020;
   localparam logic [31:0] ADDR_SPURIOUS_VECTOR_CONTROL = 32'hFEE0_00F0;
   localparam logic [31:0] ADDR_INTERRUPT_COMMAND_LOW   = 32'hFEE0_0300;
   localparam logic [31:0] ADDR_INTERRUPT_COMMAND_HIGH  = 32'hFEE0_0310;
   localparam logic [31:0] ADDR_LOCAL_PIN0_VECTOR_ENTRY = 32'hFEE0_0350;
   localparam logic [31:0] ADDR_LOCAL_PIN1_VECTOR_ENTRY = 32'hFEE0_0360;
   localparam logic [31:0] ADDR_ERROR_VECTOR_ENTRY      = 32'hFEE0_0370;

   // ==========================================================================
   // Field layout
   // ==========================================================================
   localparam int UNIT_ENABLE_BIT = 8;
   localparam int ID_LSB          = 24;
   localparam int ID_W            = 4;
   localparam int VEC_LSB         = 0;
   localparam int VEC_W           = 8;
   localparam int MODE_LSB        = 8;
   localparam int MODE_W          = 3;
   localparam int PENDING_BIT     = 12;
   localparam int POLARITY_BIT    = 13;
   localparam int TRIGGER_BIT     = 15;
   localparam int MASK_BIT        = 16;
   localparam int PAGE_SHIFT      = 12;
   localparam int START_ADDR_W    = 20;

   // ==========================================================================
   // Delivery modes
   // ==========================================================================
   localparam logic [MODE_W-1:0] MODE_STARTUP  = 3'h6;
   localparam logic [MODE_W-1:0] MODE_EXT_CTRL = 3'h7;
   localparam logic [MODE_W-1:0] MODE_NMI      = 3'h4;

   // ==========================================================================
   // Reset values and timing
   // ==========================================================================
   localparam logic [31:0] RST_SPURIOUS_VECTOR_CONTROL = 32'h0000_0000;
   localparam logic [31:0] RST_COMMAND                 = 32'h0000_0000;
   localparam logic [31:0] RST_VECTOR_ENTRY            = 32'h0001_0000;
   localparam logic [ID_W-1:0] RST_LOCAL_ID            = 4'h0;
   localparam logic [31:0] UNMAPPED_READ               = 32'h0000_0000;
   localparam int          ACK_WAIT_CYCLES             = 256;
   localparam int          ACK_CNT_W                   = 16;

   // ==========================================================================
   // Carrier types
   // ==========================================================================
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [31:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic                    valid;
      logic [ID_W-1:0]         dest;
      logic [MODE_W-1:0]       mode;
      logic [VEC_W-1:0]        vector;
      logic [START_ADDR_W-1:0] start_addr;
   } inter_processor_message_t;

   typedef enum logic [2:0] {
      SEND_IDLE = 3'b001,
      SEND_WAIT = 3'b010,
      SEND_FAIL = 3'b100
   } send_state_t;

endpackage

/* File: local_pin_event_detect.sv */
// Polarity and trigger-mode qualifier for one local interrupt pin.
module local_pin_event_detect (
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_nrst,
   // Pin and its configuration
   input  wire logic i_pin,
   input  wire logic i_active_low,
   input  wire logic i_level_mode,
   // Qualified event
   output logic      o_event
);

   typedef struct packed {
      logic prev;
      logic event_out;
   } pin_state_t;

   pin_state_t state_r;
   pin_state_t state_nxt;
   logic       asserted;

   // ==========================================================================
   // Next state
   // ==========================================================================
   always_comb begin
      asserted            = i_pin ^ i_active_low;
      state_nxt           = state_r;
      state_nxt.prev      = asserted;
      // Edge mode gives a one-cycle pulse; level mode follows the input.
      if (i_level_mode) begin
         state_nxt.event_out = asserted;
      end else begin
         state_nxt.event_out = asserted & ~state_r.prev;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign o_event = state_r.event_out;

endmodule // local_pin_event_detect

/* File: peer_unit_model.sv */
// Behavioural peer unit: style 1 acks each message, 2 rejects it, 3 stays silent.
module peer_unit_model (
   // Clock, message in, answer style
   input  wire logic                                              i_ref_clk,
   input  wire local_interrupt_unit_pkg::inter_processor_message_t i_msg,
   input  wire logic [1:0]                                        i_style,
   // Answer to the sender
   output logic                                                   o_ack,
   output logic                                                   o_reject
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {o_ack, o_reject} = 2'b00;
   // The answer comes two cycles late so the sender is really seen waiting.
   always @(posedge i_ref_clk) begin
      {o_ack, o_reject} <= 2'b00;
      if (i_msg.valid === 1'b1) begin
         repeat (2) @(posedge i_ref_clk);
         {o_ack, o_reject} <= {i_style == 2'h1, i_style == 2'h2};
      end
   end
endmodule // peer_unit_model

/* File: tb_local_interrupt_unit.sv */
// Self-checking testbench of the local interrupt unit with a peer model.
module tb_local_interrupt_unit;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_ID  = local_interrupt_unit_pkg::ADDR_LOCAL_UNIT_IDENTIFIER;
   localparam logic [31:0] A_SVC = local_interrupt_unit_pkg::ADDR_SPURIOUS_VECTOR_CONTROL;
   localparam logic [31:0] A_ERR = local_interrupt_unit_pkg::ADDR_ERROR_VECTOR_ENTRY;
   localparam logic [31:0] A_LOW = local_interrupt_unit_pkg::ADDR_INTERRUPT_COMMAND_LOW;
   local_interrupt_unit_pkg::reg_req_t                 req = '0;
   local_interrupt_unit_pkg::inter_processor_message_t msg;

   logic        ref_clk = 1'b0, nrst = 1'b0, pin0 = 1'b0, pin1 = 1'b0;
   logic [1:0]  style = 2'h1;
   logic [31:0] rdata;
   logic [7:0]  errv;
   logic        rd_valid, mi, nmi, err, en, ack, rej;
   int          n_errors = 0, tests_run = 0, cyc = 0;
   always #10 ref_clk = ~ref_clk;
   local_interrupt_unit #(.ACK_WAIT(8)) DUT (
      .i_ref_clk(ref_clk), .i_nrst(nrst), .i_req(req), .o_rdata(rdata), .o_rd_valid(rd_valid),
      .i_local_pin0(pin0), .i_local_pin1(pin1), .o_msg(msg), .i_msg_ack(ack),
      .i_msg_reject(rej), .o_maskable_int(mi), .o_nmi(nmi), .o_err_irq(err),
      .o_err_vector(errv), .o_unit_enabled(en));
   peer_unit_model peer (.i_ref_clk(ref_clk), .i_msg(msg), .i_style(style), .o_ack(ack),
      .o_reject(rej));
   // ==========================================================================
   // Shared tasks
   task automatic results();
      if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk) req <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk) req <= '0;
   endtask
   task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
      @(posedge ref_clk) req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge ref_clk) req <= '0;
      #1 chk(n, rd_valid === 1'b1 ? rdata : ~e, e);
   endtask
   // Pins are low while an entry is written, and go low again only after the masked entry is written back.
   task automatic pin(input logic s, input logic [31:0] e, input logic [1:0] p, x);
      logic [31:0] a;
      logic [1:0]  seen;
      a = s ? local_interrupt_unit_pkg::ADDR_LOCAL_PIN1_VECTOR_ENTRY
            : local_interrupt_unit_pkg::ADDR_LOCAL_PIN0_VECTOR_ENTRY;
      seen = 2'h0;
      wr(a, e);
      @(posedge ref_clk) {pin1, pin0} <= p;
      repeat (4) begin
         @(posedge ref_clk);
         #1 seen = seen | {nmi, mi};
      end
      chk("pin", seen, x);
      wr(a, 32'h0001_0000);
      {pin1, pin0} <= 2'h0;
   endtask
   // ==========================================================================
   // Scenarios
   task automatic t_reset();
      rd("svr", A_SVC, 32'h0);
      rd("id", A_ID, 32'h0);
      rd("err", A_ERR, 32'h0001_0000);
      rd("gap", 32'hFEE0_0400, 32'h0);
      chk("en", en, 32'h0);
   endtask
   task automatic t_ident();
      wr(A_ID, 32'hFFFF_FFFF);
      rd("idf", A_ID, 32'h0F00_0000);
      wr(A_ID, 32'h0100_0000);
      rd("idn", A_ID, 32'h0100_0000);
   endtask
   task automatic t_send();
      wr(A_LOW, 32'h0000_06BD);
      #1 chk("off", msg.valid, 32'h0);
      wr(A_SVC, 32'h0000_0100);
      #1 chk("en", en, 32'h1);
      wr(A_ERR, 32'h0000_A055);
      rd("keep", A_ERR, 32'h0000_A055);
      wr(local_interrupt_unit_pkg::ADDR_INTERRUPT_COMMAND_HIGH, 32'h0100_0000);
      wr(A_LOW, 32'h0000_06BD);
      #1 chk("msg", {msg.valid, msg.dest, msg.mode, msg.vector}, {1'b1, 4'h1, 3'h6, 8'hBD});
      chk("page", msg.start_addr, 20'hBD000);
      repeat (6) @(posedge ref_clk);
      rd("low", A_LOW, 32'h0000_06BD);
   endtask
   task automatic t_errors();
      logic seen;
      for (int m = 1; m < 4; m++) begin
         style <= 2'(m);
         seen = 1'b0;
         wr(A_LOW, 32'h0000_0610);
         repeat (20) begin
            @(posedge ref_clk);
            #1 seen = seen | err;
         end
         chk("errirq", seen, m != 1);
         if (m != 1) chk("errvec", errv, 32'h55);
      end
   endtask
   task automatic t_pins();
      pin(1'b0, 32'h0000_0700, 2'b01, 2'b01);
      pin(1'b1, 32'h0000_0400, 2'b10, 2'b10);
      pin(1'b0, 32'h0001_0700, 2'b01, 2'b00);
      pin(1'b1, 32'h0000_A400, 2'b00, 2'b10);
      wr(A_SVC, 32'h0);
      pin(1'b0, 32'h0000_0700, 2'b01, 2'b00);
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset();
      t_ident();
      t_send();
      t_errors();
      t_pins();
      results();
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         results();
      end
   end
endmodule // tb_local_interrupt_unit
